// file: core/aclkg_pkg.sv
// audio clock generator: register map, field layout, reset values and widths
package aclkg_pkg;

    // ------------------------------------------------------------
    // register subaddresses
    // ------------------------------------------------------------
    localparam logic [7:0] ACLKG_ADDR_CNT_LO = 8'h30;
    localparam logic [7:0] ACLKG_ADDR_CNT_MID = 8'h31;
    localparam logic [7:0] ACLKG_ADDR_CNT_HI = 8'h32;
    localparam logic [7:0] ACLKG_ADDR_INC_LO = 8'h34;
    localparam logic [7:0] ACLKG_ADDR_INC_MID = 8'h35;
    localparam logic [7:0] ACLKG_ADDR_INC_HI = 8'h36;
    localparam logic [7:0] ACLKG_ADDR_BDIV = 8'h38;
    localparam logic [7:0] ACLKG_ADDR_CDIV = 8'h39;
    localparam logic [7:0] ACLKG_ADDR_CTRL = 8'h3a;
    localparam logic [7:0] ACLKG_ADDR_STATUS = 8'h3b;

    // ------------------------------------------------------------
    // field widths and bit positions
    // ------------------------------------------------------------
    localparam int ACLKG_CNT_W = 18;
    localparam int ACLKG_INC_W = 22;
    localparam int ACLKG_DIV_W = 6;
    localparam int ACLKG_CTRL_W = 4;
    localparam int ACLKG_PLL_OPEN_BIT = 3;
    localparam int ACLKG_VREF_SEL_BIT = 2;
    localparam int ACLKG_CPHASE_BIT = 1;
    localparam int ACLKG_BPHASE_BIT = 0;
    localparam int ACLKG_STAT_LOCK_BIT = 0;

    // ------------------------------------------------------------
    // synthesis datapath
    // ------------------------------------------------------------
    localparam int ACLKG_ACC_W = 24;
    localparam int ACLKG_TRIM_W = 16;
    localparam logic [15:0] ACLKG_TRIM_MAX = 16'h7fff;
    localparam logic [15:0] ACLKG_TRIM_MIN = 16'h8000;
    localparam logic [15:0] ACLKG_TRIM_STEP = 16'h0001;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [17:0] ACLKG_RST_CNT = 18'h00000;
    localparam logic [21:0] ACLKG_RST_INC = 22'h000000;
    localparam logic [5:0] ACLKG_RST_DIV = 6'h00;
    localparam logic [3:0] ACLKG_RST_CTRL = 4'h0;
    localparam logic [7:0] ACLKG_RST_RDATA = 8'h00;

endpackage

// file: core/aclkg_divider.sv
// audio clock generator: edge-counting clock divider with launch phase select
`timescale 1ns/1ps
`default_nettype none
module aclkg_divider
    import aclkg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic src_rise,
    input wire logic src_fall,
    input wire logic launch_on_rise,
    input wire logic [ACLKG_DIV_W-1:0] ratio,
    output logic clk_out_r,
    output logic out_rise_r,
    output logic out_fall_r
);

    logic [ACLKG_DIV_W-1:0] cnt_r;
    logic [ACLKG_DIV_W-1:0] limit;
    logic [ACLKG_DIV_W-1:0] cnt_inc;
    logic launch;
    logic hit;

    // ------------------------------------------------------------
    // launch edge and terminal count
    // ------------------------------------------------------------
    // a zero ratio acts as one so the output never freezes
    assign limit = (ratio == 6'h00) ? 6'h01 : ratio;
    assign cnt_inc = cnt_r + 6'h01;
    assign launch = launch_on_rise ? src_rise : src_fall;
    // >= so a ratio lowered mid-count still terminates
    assign hit = launch && (cnt_inc >= limit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 6'h00;
        end else if (hit) begin
            cnt_r <= 6'h00;
        end else if (launch) begin
            cnt_r <= cnt_inc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_out_r <= 1'b0;
            out_rise_r <= 1'b0;
            out_fall_r <= 1'b0;
        end else begin
            clk_out_r <= hit ? ~clk_out_r : clk_out_r;
            out_rise_r <= hit && !clk_out_r;
            out_fall_r <= hit && clk_out_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_out_launch: assert property (@(posedge clk) disable iff (rst)
        $changed(clk_out_r) |-> $past(launch_on_rise ? src_rise : src_fall))
        else $error("divided clock moved without a selected source edge");

    chk_out_period: assert property (@(posedge clk) disable iff (rst)
        (launch && !hit && $stable(ratio)) |=> $stable(clk_out_r))
        else $error("divided clock toggled before terminal count");

endmodule
`default_nettype wire

// file: core/aclkg_top.sv
// audio clock generator: registers, field-locked master clock synthesis, dividers
//
// Behaviour
// - 18-bit master cycles-per-field count at 30H-32H
// - 22-bit nominal increment at 34H-36H
// - 6-bit master to bit clock divider
// - 6-bit bit to channel clock divider
// - pll open bit: locked or free-running
// - vertical reference from decoder or expansion port
// - channel clock launched on chosen bit edge
// - bit clock launched on chosen master edge
`timescale 1ns/1ps
`default_nettype none
module aclkg_top
    import aclkg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r,
    input wire logic decoder_vref,
    input wire logic expansion_vertical_ref_input,
    output logic audio_master_clock,
    output logic audio_serial_bit_clock,
    output logic audio_channel_select_clock
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [ACLKG_CNT_W-1:0] field_cycle_count_r;
    logic [ACLKG_INC_W-1:0] nominal_increment_r;
    logic [ACLKG_DIV_W-1:0] master_to_bit_clock_divider_r;
    logic [ACLKG_DIV_W-1:0] bit_to_channel_clock_divider_r;
    logic [ACLKG_CTRL_W-1:0] ctrl_r;
    logic audio_pll_open;
    logic audio_vref_select;
    logic channel_clock_phase;
    logic bit_clock_phase;

    assign audio_pll_open = ctrl_r[ACLKG_PLL_OPEN_BIT];
    assign audio_vref_select = ctrl_r[ACLKG_VREF_SEL_BIT];
    assign channel_clock_phase = ctrl_r[ACLKG_CPHASE_BIT];
    assign bit_clock_phase = ctrl_r[ACLKG_BPHASE_BIT];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // count bytes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            field_cycle_count_r <= ACLKG_RST_CNT;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_CNT_LO) begin
            field_cycle_count_r[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_CNT_MID) begin
            field_cycle_count_r[15:8] <= reg_wdata;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_CNT_HI) begin
            field_cycle_count_r[17:16] <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nominal_increment_r <= ACLKG_RST_INC;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_INC_LO) begin
            nominal_increment_r[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_INC_MID) begin
            nominal_increment_r[15:8] <= reg_wdata;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_INC_HI) begin
            nominal_increment_r[21:16] <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_to_bit_clock_divider_r <= ACLKG_RST_DIV;
            bit_to_channel_clock_divider_r <= ACLKG_RST_DIV;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_BDIV) begin
            master_to_bit_clock_divider_r <= reg_wdata[5:0];
        end else if (reg_wr && reg_addr == ACLKG_ADDR_CDIV) begin
            bit_to_channel_clock_divider_r <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= ACLKG_RST_CTRL;
        end else if (reg_wr && reg_addr == ACLKG_ADDR_CTRL) begin
            ctrl_r <= reg_wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    logic locked_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        if (reg_addr == ACLKG_ADDR_CNT_LO) begin
            rdata_nxt = field_cycle_count_r[7:0];
        end else if (reg_addr == ACLKG_ADDR_CNT_MID) begin
            rdata_nxt = field_cycle_count_r[15:8];
        end else if (reg_addr == ACLKG_ADDR_CNT_HI) begin
            rdata_nxt = {6'h00, field_cycle_count_r[17:16]};
        end else if (reg_addr == ACLKG_ADDR_INC_LO) begin
            rdata_nxt = nominal_increment_r[7:0];
        end else if (reg_addr == ACLKG_ADDR_INC_MID) begin
            rdata_nxt = nominal_increment_r[15:8];
        end else if (reg_addr == ACLKG_ADDR_INC_HI) begin
            rdata_nxt = {2'h0, nominal_increment_r[21:16]};
        end else if (reg_addr == ACLKG_ADDR_BDIV) begin
            rdata_nxt = {2'h0, master_to_bit_clock_divider_r};
        end else if (reg_addr == ACLKG_ADDR_CDIV) begin
            rdata_nxt = {2'h0, bit_to_channel_clock_divider_r};
        end else if (reg_addr == ACLKG_ADDR_CTRL) begin
            rdata_nxt = {4'h0, ctrl_r};
        end else if (reg_addr == ACLKG_ADDR_STATUS) begin
            rdata_nxt = {7'h00, locked_r};
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= ACLKG_RST_RDATA;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // vertical reference
    // ------------------------------------------------------------
    logic vref_sel;
    logic vref_d_r;
    logic vref_pulse;

    assign vref_sel = audio_vref_select ? expansion_vertical_ref_input : decoder_vref;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vref_d_r <= 1'b0;
        end else begin
            vref_d_r <= vref_sel;
        end
    end

    // switching the source can fake one edge; the loop absorbs one bad field
    assign vref_pulse = vref_sel && !vref_d_r;

    // ------------------------------------------------------------
    // field lock loop
    // ------------------------------------------------------------
    logic [ACLKG_CNT_W:0] field_cnt_r;
    logic [ACLKG_TRIM_W-1:0] trim_r;
    logic mclk_rise_r;
    logic mclk_fall_r;
    logic cnt_short;
    logic cnt_long;

    assign cnt_short = field_cnt_r < {1'b0, field_cycle_count_r};
    assign cnt_long = field_cnt_r > {1'b0, field_cycle_count_r};

    // master cycles counted per reference interval, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            field_cnt_r <= '0;
        end else if (vref_pulse) begin
            field_cnt_r <= {18'h00000, mclk_rise_r};
        end else if (mclk_rise_r && field_cnt_r != '1) begin
            field_cnt_r <= field_cnt_r + 19'h00001;
        end
    end

    // one step per field keeps jitter low at the cost of pull-in time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trim_r <= '0;
            locked_r <= 1'b0;
        end else if (audio_pll_open) begin
            trim_r <= '0;
            locked_r <= 1'b0;
        end else if (vref_pulse) begin
            locked_r <= !cnt_short && !cnt_long;
            if (cnt_short && trim_r != ACLKG_TRIM_MAX) begin
                trim_r <= trim_r + ACLKG_TRIM_STEP;
            end else if (cnt_long && trim_r != ACLKG_TRIM_MIN) begin
                trim_r <= trim_r - ACLKG_TRIM_STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // master clock synthesis
    // ------------------------------------------------------------
    logic [ACLKG_ACC_W-1:0] acc_r;
    logic [ACLKG_ACC_W-1:0] inc_eff;
    logic [ACLKG_ACC_W-1:0] acc_nxt;

    // phase accumulator, master clock is its top bit
    assign inc_eff = {2'h0, nominal_increment_r} + {{8{trim_r[15]}}, trim_r};
    assign acc_nxt = acc_r + inc_eff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= '0;
            audio_master_clock <= 1'b0;
            mclk_rise_r <= 1'b0;
            mclk_fall_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            audio_master_clock <= acc_nxt[ACLKG_ACC_W-1];
            mclk_rise_r <= acc_nxt[ACLKG_ACC_W-1] && !audio_master_clock;
            mclk_fall_r <= !acc_nxt[ACLKG_ACC_W-1] && audio_master_clock;
        end
    end

    // ------------------------------------------------------------
    // bit and channel clock dividers
    // ------------------------------------------------------------
    logic bclk_rise_r;
    logic bclk_fall_r;

    aclkg_divider u_bit_div (
        .clk(clk),
        .rst(rst),
        .src_rise(mclk_rise_r),
        .src_fall(mclk_fall_r),
        .launch_on_rise(bit_clock_phase),
        .ratio(master_to_bit_clock_divider_r),
        .clk_out_r(audio_serial_bit_clock),
        .out_rise_r(bclk_rise_r),
        .out_fall_r(bclk_fall_r)
    );

    // channel clock from bit clock edges
    aclkg_divider u_chan_div (
        .clk(clk),
        .rst(rst),
        .src_rise(bclk_rise_r),
        .src_fall(bclk_fall_r),
        .launch_on_rise(channel_clock_phase),
        .ratio(bit_to_channel_clock_divider_r),
        .clk_out_r(audio_channel_select_clock),
        .out_rise_r(),
        .out_fall_r()
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_write_cdiv;
        reg_wr && reg_addr == ACLKG_ADDR_CDIV;
    endsequence

    sequence s_read_cdiv;
        reg_rd && !reg_wr && reg_addr == ACLKG_ADDR_CDIV;
    endsequence

    chk_cdiv_readback: assert property (
        s_write_cdiv ##1 s_read_cdiv |=> reg_rdata_r == ($past(reg_wdata, 2) & 8'h3f))
        else $error("channel divider read back wrong");

    chk_cnt_hi_zero: assert property (
        (reg_rd && reg_addr == ACLKG_ADDR_CNT_HI) |=> reg_rdata_r[7:2] == 6'h00)
        else $error("count high byte shows unused bits");

    chk_inc_hi_zero: assert property (
        (reg_rd && reg_addr == ACLKG_ADDR_INC_HI) |=> reg_rdata_r[7:6] == 2'h0)
        else $error("increment high byte shows unused bits");

    chk_bdiv_zero: assert property (
        (reg_rd && reg_addr == ACLKG_ADDR_BDIV) |=>
        reg_rdata_r == {2'h0, master_to_bit_clock_divider_r})
        else $error("bit divider read back wrong");

    chk_open_no_trim: assert property (
        audio_pll_open |=> trim_r == '0 && !locked_r)
        else $error("open loop still trims");

    chk_vref_source: assert property (
        (audio_vref_select && $rose(expansion_vertical_ref_input) && $stable(ctrl_r))
        |-> vref_pulse)
        else $error("expansion reference edge missed");

    chk_trim_up: assert property (
        (!audio_pll_open && vref_pulse && cnt_short && trim_r != ACLKG_TRIM_MAX
        && !(reg_wr && reg_addr == ACLKG_ADDR_CTRL))
        |=> trim_r == $past(trim_r) + ACLKG_TRIM_STEP)
        else $error("short field did not raise the trim");

    chk_mclk_edge: assert property (
        $rose(audio_master_clock) |-> mclk_rise_r ##1 !mclk_rise_r)
        else $error("master rise pulse out of step");

endmodule
`default_nettype wire

// file: bench/aclkg_receiver.sv
// far-side model: serial audio receiver measuring the clocks it is handed
`timescale 1ns/1ps
`default_nettype none
module aclkg_receiver (
    input wire logic clk,
    input wire logic rst,
    input wire logic bit_clk,
    input wire logic chan_clk,
    input wire logic chan_on_rise,
    output int bits_half,
    output int chan_skew,
    output int rise_period
);
    // ------------------------------------------------------------
    // edge bookkeeping
    // ------------------------------------------------------------
    logic bq;
    logic cq;
    int rises;
    int t_rise;
    int t_fall;
    int t_last;

    // edge launch skew
    // sampled on the system clock, so skews are whole clk cycles from the launching edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bq = 1'b0;
            cq = 1'b0;
            rises = 0;
            t_rise = 0;
            t_fall = 0;
            t_last = 0;
            bits_half = 0;
            chan_skew = 0;
            rise_period = 0;
        end else begin
            t_rise++;
            t_fall++;
            t_last++;
            if (bit_clk && !bq) begin
                rises++;
                t_rise = 0;
                rise_period = t_last;
                t_last = 0;
            end
            if (!bit_clk && bq) begin
                t_fall = 0;
            end
            if (chan_clk != cq) begin
                bits_half = rises;
                rises = 0;
                chan_skew = chan_on_rise ? t_rise : t_fall;
            end
            bq = bit_clk;
            cq = chan_clk;
        end
    end
endmodule
`default_nettype wire

// file: bench/tb.sv
// testbench: registers, clock ratios, launch phases and field lock of the audio clock block
`timescale 1ns/1ps
`default_nettype none
module tb
    import aclkg_pkg::*;
;
    logic clk;
    logic rst;
    logic reg_wr;
    logic reg_rd;
    logic decoder_vref;
    logic exp_vref;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata_r;
    logic master_clk;
    logic bit_clk;
    logic chan_clk;
    logic bphase;
    logic cphase;
    int bad_count;
    int comparisons;
    int seed;
    int master_per;
    int bit_per;
    int bits_per_bit;
    int bits_per_chan;
    int bit_skew;
    int chan_skew;
    int n;
    int m;
    int mp;
    int mdl [int];
    int msk [int] = '{8'h30: 8'hff, 8'h31: 8'hff, 8'h32: 8'h03, 8'h34: 8'hff, 8'h35: 8'hff,
                      8'h36: 8'h3f, 8'h38: 8'h3f, 8'h39: 8'h3f, 8'h3a: 8'h0f};
    int adr [$] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3a,
                    8'h33, 8'h37, 8'h3b, 8'h3c, 8'h00};

    aclkg_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .decoder_vref(decoder_vref), .expansion_vertical_ref_input(exp_vref),
        .audio_master_clock(master_clk), .audio_serial_bit_clock(bit_clk),
        .audio_channel_select_clock(chan_clk));
    aclkg_receiver u_rx (.clk(clk), .rst(rst), .bit_clk(bit_clk), .chan_clk(chan_clk),
        .chan_on_rise(cphase), .bits_half(bits_per_chan), .chan_skew(chan_skew),
        .rise_period(bit_per));
    aclkg_receiver u_mon (.clk(clk), .rst(rst), .bit_clk(master_clk), .chan_clk(bit_clk),
        .chan_on_rise(bphase), .bits_half(bits_per_bit), .chan_skew(bit_skew),
        .rise_period(master_per));

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_num(input string nm, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    function automatic logic [7:0] mexp(input int a);
        return msk.exists(a) ? 8'(mdl[a]) : 8'h00;
    endfunction

    // status model: master period 16 clk, field 160 clk, so 10 rises per field
    function automatic logic [7:0] st(input int cnt);
        return (160 / 16 == cnt) ? 8'h01 : 8'h00;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        if (msk.exists(int'(a))) mdl[int'(a)] = int'(d) & msk[int'(a)];
        if (a == ACLKG_ADDR_CTRL) begin
            bphase = d[0];
            cphase = d[1];
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk_reg($sformatf("register %h", a), exp, reg_rdata_r);
    endtask

    // reference pulses every 160 clk, high for 4
    task automatic pulses(input bit on_exp, input int cnt);
        repeat (cnt) begin
            @(negedge clk);
            if (on_exp) exp_vref = 1'b1;
            else decoder_vref = 1'b1;
            repeat (4) @(negedge clk);
            exp_vref = 1'b0;
            decoder_vref = 1'b0;
            repeat (155) @(negedge clk);
        end
    endtask

    task automatic give_verdict;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        seed = 32'h8f88c8de;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        decoder_vref = 1'b0;
        exp_vref = 1'b0;
        bphase = 1'b0;
        cphase = 1'b0;
        foreach (msk[a]) mdl[a] = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        foreach (adr[i]) rd_chk(adr[i][7:0], mexp(adr[i]));
        // random bytes everywhere, unmapped and status writes must leave no trace
        for (int r = 0; r < 4; r++) begin
            foreach (adr[i]) wr(adr[i][7:0], 8'($random(seed)));
            foreach (adr[i]) rd_chk(adr[i][7:0], mexp(adr[i]));
        end
        // write then read in the very next cycle, as a host may do
        @(negedge clk);
        reg_addr = ACLKG_ADDR_CDIV;
        reg_wdata = 8'($random(seed));
        reg_wr = 1'b1;
        mdl[8'h39] = int'(reg_wdata) & 8'h3f;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk_reg("channel divider back to back", mexp(8'h39), reg_rdata_r);
        // free-running clock table: every phase pair, divider 0 read as 1
        for (int k = 0; k < 4; k++) begin
            wr(ACLKG_ADDR_INC_LO, 8'h00);
            wr(ACLKG_ADDR_INC_MID, 8'h00);
            wr(ACLKG_ADDR_INC_HI, (k % 2) ? 8'h10 : 8'h20);
            wr(ACLKG_ADDR_BDIV, 8'(k));
            wr(ACLKG_ADDR_CDIV, 8'(3 - k));
            wr(ACLKG_ADDR_CTRL, 8'(8 + k));
            repeat (1200) @(negedge clk);
            n = (k == 0) ? 1 : k;
            m = (k == 3) ? 1 : 3 - k;
            mp = (k % 2) ? 16 : 8;
            chk_num("master period", mp, master_per);
            chk_num("master edges per bit half", n, bits_per_bit);
            chk_num("bit period", 2 * n * mp, bit_per);
            chk_num("bit clock skew", 1, bit_skew);
            chk_num("bit edges per channel half", m, bits_per_chan);
            chk_num("channel clock skew", 1, chan_skew);
        end
        // field lock: first field after a switch may miscount, so several pulses each time
        wr(ACLKG_ADDR_INC_HI, 8'h10);
        wr(ACLKG_ADDR_CNT_LO, 8'h0a);
        wr(ACLKG_ADDR_CNT_MID, 8'h00);
        wr(ACLKG_ADDR_CNT_HI, 8'h00);
        wr(ACLKG_ADDR_CTRL, 8'h00);
        pulses(1'b0, 4);
        rd_chk(ACLKG_ADDR_STATUS, st(10));
        wr(ACLKG_ADDR_CNT_LO, 8'h0b);
        pulses(1'b0, 3);
        rd_chk(ACLKG_ADDR_STATUS, st(11));
        wr(ACLKG_ADDR_CNT_LO, 8'h0a);
        wr(ACLKG_ADDR_CTRL, 8'h04);
        pulses(1'b0, 3);
        rd_chk(ACLKG_ADDR_STATUS, st(11));
        pulses(1'b1, 3);
        rd_chk(ACLKG_ADDR_STATUS, st(10));
        wr(ACLKG_ADDR_CNT_HI, 8'h01);
        pulses(1'b1, 3);
        rd_chk(ACLKG_ADDR_STATUS, st(32'h1000a));
        wr(ACLKG_ADDR_CNT_HI, 8'h00);
        wr(ACLKG_ADDR_CTRL, 8'h0c);
        pulses(1'b1, 3);
        rd_chk(ACLKG_ADDR_STATUS, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
